// [core/smbc_top.sv]
// Overview of operation
// - After start and matching write address, the device acknowledges the address.
// - Next byte is the start index, acknowledged and used as first location.
// - In a write the byte count follows and is acknowledged before data.
// - Each data byte up to the count is stored at ascending locations and acknowledged singly.
// - Read: index written, repeated start, read address acknowledged by device.
// - Device sends the count byte first, then bytes from index onward.
// - Bus address comes from the address strap, latched once after reset.
// - Byte 0 holds output gate bits at 7,6,4,3,2,0, reset enabled.
// - A zero gate bit forces that output low, whatever its gate pin.
// - Byte 1 bits 7:6 read back the latched three-level spread strap.
// - Byte 1 bit 5 gives software control of spread; else strap governs.
// - Byte 1 bits 4:3 select spread off, -0.25%, reserved, -0.5%.
// - Byte 1 bits 1:0 select output amplitude, reset value binary 10.
// - Byte 2 holds per-output edge speed bits, one is fast, reset fast.
// - Byte 7 bits 4:0 set the read byte count, default eight.
`timescale 1ns/1ns
module smbc_top
  import smbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_strap_i,
  input wire logic [1:0] spread_strap_i,
  input wire logic [5:0] out_gate_n_i,
  output logic [5:0] diff_out_en_o,
  output logic [1:0] spread_mode_o,
  output logic [1:0] amplitude_o,
  output logic [5:0] edge_fast_o
);
  typedef struct packed {
    smbc_phase_e ph;
    logic [3:0] bitn;
    logic ackslot;
    logic pend;
    logic tx;
    logic host_ack;
    logic [7:0] sh;
    logic [7:0] idx;
    logic [7:0] left;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic scl_oe;
    logic strap_done;
    logic addr_sel;
    logic [1:0] strap;
    logic [5:0] gate;
    logic [1:0] spread;
    logic [1:0] amp;
    logic [5:0] edge_fast;
  } smbc_top_s;

  // Picks the six per-output bits out of a gate or edge byte
  function automatic logic [5:0] smbc_pick6(input logic [7:0] b);
    smbc_pick6 = {b[7], b[6], b[4], b[3], b[2], b[0]};
  endfunction

  smbc_top_s q, d;
  smbc_cfg_if cfg ();

  logic rise, fall, start_c, stop_c;
  logic push_v;
  logic fifo_in_ready, fifo_out_valid;
  logic [SMBC_FIFO_WIDTH-1:0] fifo_out_data;
  logic load_req, load_count;
  logic [7:0] rd_addr_c;
  logic rd_en_c;

  smbc_fifo #(
    .WIDTH(SMBC_FIFO_WIDTH),
    .DEPTH(SMBC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(push_v),
    .in_ready_o(fifo_in_ready),
    .in_data_i({q.idx, q.sh}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(cfg.wr_ready),
    .out_data_o(fifo_out_data)
  );

  smbc_cfg_regs u_regs (
    .clk_i(sys_clk_i),
    .reset_i(reset_i),
    .cfg(cfg.regs)
  );

  assign cfg.wr_valid = fifo_out_valid;
  assign cfg.wr_addr = fifo_out_data[15:8];
  assign cfg.wr_data = fifo_out_data[7:0];
  assign cfg.rd_en = rd_en_c;
  assign cfg.rd_addr = rd_addr_c;
  assign cfg.strap = q.strap;

  always_comb begin
    d = q;
    push_v = 1'b0;
    load_req = 1'b0;
    load_count = 1'b0;
    rd_en_c = 1'b0;
    rd_addr_c = q.idx;
    rise = !q.scl_p && scl_i;
    fall = (q.scl_p && !scl_i) || q.pend;
    start_c = q.scl_p && scl_i && q.sda_p && !sda_i;
    stop_c = q.scl_p && scl_i && !q.sda_p && sda_i;
    d.scl_p = scl_i;
    d.sda_p = sda_i;

    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.addr_sel = addr_strap_i;
      d.strap = spread_strap_i;
    end else if (start_c || stop_c) begin
      d.ph = start_c ? PH_ADDR : PH_IDLE;
      d.bitn = '0;
      d.ackslot = 1'b0;
      d.tx = 1'b0;
      d.pend = 1'b0;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end else if (q.ph == PH_IDLE || q.ph == PH_SKIP) begin
      d.sda_oe = 1'b0;
    end else if (rise) begin
      if (q.bitn != SMBC_BYTE_BITS) begin
        d.bitn = q.bitn + 1'b1;
        if (!q.tx) begin
          d.sh = {q.sh[6:0], sda_i};
        end
      end else if (q.tx && q.ackslot) begin
        d.host_ack = !sda_i;
      end
    end else if (fall) begin
      d.pend = 1'b0;
      d.scl_oe = 1'b0;
      if (q.bitn != SMBC_BYTE_BITS) begin
        if (q.tx && q.bitn != '0) begin
          d.sh = {q.sh[6:0], 1'b0};
          d.sda_oe = !q.sh[6];
        end
      end else if (!q.ackslot) begin
        d.ackslot = 1'b1;
        if (q.tx) begin
          d.sda_oe = 1'b0;
        end else begin
          case (q.ph)
            PH_ADDR: begin
              if (q.sh[7:1] == (q.addr_sel ? SMBC_ADDR_SEL1 : SMBC_ADDR_SEL0)) begin
                d.sda_oe = 1'b1;
              end else begin
                d.ph = PH_SKIP;
              end
            end
            PH_INDEX: begin
              d.idx = q.sh;
              d.sda_oe = 1'b1;
            end
            PH_COUNT: begin
              d.left = q.sh;
              d.sda_oe = 1'b1;
            end
            PH_WDATA: begin
              if (q.left == 8'h00) begin
                d.ph = PH_SKIP;
              end else begin
                push_v = 1'b1;
                if (fifo_in_ready) begin
                  d.sda_oe = 1'b1;
                  d.left = q.left - 1'b1;
                  d.idx = q.idx + 1'b1;
                end else begin
                  d.ackslot = 1'b0;
                  d.pend = 1'b1;
                  d.scl_oe = 1'b1;
                end
              end
            end
            default: begin
              d.ph = PH_SKIP;
            end
          endcase
        end
      end else begin
        d.ackslot = 1'b0;
        d.bitn = '0;
        d.sda_oe = 1'b0;
        case (q.ph)
          PH_ADDR: begin
            if (q.sh[0]) begin
              load_req = 1'b1;
              load_count = 1'b1;
            end else begin
              d.ph = PH_INDEX;
            end
          end
          PH_INDEX: begin
            d.ph = PH_COUNT;
          end
          PH_COUNT: begin
            d.ph = PH_WDATA;
          end
          PH_TX: begin
            if (q.host_ack) begin
              load_req = 1'b1;
            end else begin
              d.ph = PH_SKIP;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Reads wait until every written byte has reached the registers
    if (load_req) begin
      if (fifo_out_valid) begin
        d.ackslot = 1'b1;
        d.bitn = q.bitn;
        d.pend = 1'b1;
        d.scl_oe = 1'b1;
      end else begin
        rd_en_c = 1'b1;
        rd_addr_c = load_count ? SMBC_OFS_COUNT : q.idx;
        d.sh = cfg.rd_data;
        d.sda_oe = !cfg.rd_data[7];
        d.tx = 1'b1;
        d.ph = PH_TX;
        if (!load_count) begin
          d.idx = q.idx + 1'b1;
        end
      end
    end

    d.gate = smbc_pick6(cfg.gate_byte) & ~out_gate_n_i;
    d.spread = cfg.ctl_byte[SMBC_SW_EN_POS] ? cfg.ctl_byte[SMBC_SW_SEL_LSB +: 2] : q.strap;
    d.amp = cfg.ctl_byte[SMBC_AMP_LSB +: 2];
    d.edge_fast = smbc_pick6(cfg.edge_byte);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.ph <= PH_IDLE;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = q.scl_oe;
  assign sda_oe_o = q.sda_oe;
  assign diff_out_en_o = q.gate;
  assign spread_mode_o = q.spread;
  assign amplitude_o = q.amp;
  assign edge_fast_o = q.edge_fast;
endmodule // smbc_top

// [core/smbc_pkg.sv]
package smbc_pkg;
  // Bus address for each level of the address strap
  localparam logic [6:0] SMBC_ADDR_SEL0 = 7'h68;
  localparam logic [6:0] SMBC_ADDR_SEL1 = 7'h6A;

  // Configuration space offsets
  localparam logic [7:0] SMBC_OFS_GATE = 8'h00;
  localparam logic [7:0] SMBC_OFS_CTL = 8'h01;
  localparam logic [7:0] SMBC_OFS_EDGE = 8'h02;
  localparam logic [7:0] SMBC_OFS_COUNT = 8'h07;

  // Writable masks and reset values
  localparam logic [7:0] SMBC_GATE_MASK = 8'hDD;
  localparam logic [7:0] SMBC_GATE_RST = 8'hDD;
  localparam logic [7:0] SMBC_EDGE_MASK = 8'hDD;
  localparam logic [7:0] SMBC_EDGE_RST = 8'hDD;
  localparam logic [7:0] SMBC_CTL_MASK = 8'h3B;
  localparam logic [7:0] SMBC_CTL_RST = 8'h02;
  localparam logic [7:0] SMBC_CTL_RSV_ONES = 8'h04;
  localparam logic [7:0] SMBC_COUNT_MASK = 8'h1F;
  localparam logic [7:0] SMBC_COUNT_RST = 8'h08;

  // Field positions in the spread and amplitude byte
  localparam int SMBC_RB_LSB = 6;
  localparam int SMBC_SW_EN_POS = 5;
  localparam int SMBC_SW_SEL_LSB = 3;
  localparam int SMBC_AMP_LSB = 0;

  // Spread strap levels as reported in the readback field
  localparam logic [1:0] SMBC_STRAP_LOW = 2'h0;
  localparam logic [1:0] SMBC_STRAP_MID = 2'h1;
  localparam logic [1:0] SMBC_STRAP_HIGH = 2'h3;

  localparam logic [3:0] SMBC_BYTE_BITS = 4'h8;
  localparam int SMBC_FIFO_WIDTH = 16;
  localparam int SMBC_FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_INDEX,
    PH_COUNT,
    PH_WDATA,
    PH_TX,
    PH_SKIP
  } smbc_phase_e;
endpackage

// [core/smbc_cfg_if.sv]
`timescale 1ns/1ns
interface smbc_cfg_if;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [1:0] strap;
  logic [7:0] gate_byte;
  logic [7:0] ctl_byte;
  logic [7:0] edge_byte;

  modport regs (
    input wr_valid, wr_addr, wr_data, rd_en, rd_addr, strap,
    output wr_ready, rd_data, gate_byte, ctl_byte, edge_byte
  );
  modport core (
    output wr_valid, wr_addr, wr_data, rd_en, rd_addr, strap,
    input wr_ready, rd_data, gate_byte, ctl_byte, edge_byte
  );
endinterface

// [core/smbc_fifo.sv]
`timescale 1ns/1ns
module smbc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } smbc_fifo_s;

  smbc_fifo_s q, d;
  logic push, pop;

  always_comb begin
    d = q;
    push = in_valid_i && (q.cnt != FULL);
    pop = out_ready_i && (q.cnt != '0);
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready_o = (q.cnt != FULL);
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];
endmodule // smbc_fifo

// [core/smbc_cfg_regs.sv]
`timescale 1ns/1ns
module smbc_cfg_regs
  import smbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  smbc_cfg_if.regs cfg
);
  typedef struct packed {
    logic [7:0] gate;
    logic [7:0] ctl;
    logic [7:0] edge_sel;
    logic [7:0] count;
  } smbc_regs_s;

  smbc_regs_s q, d;
  logic wr;

  always_comb begin
    d = q;
    // Reads have priority, writes wait a cycle
    wr = cfg.wr_valid && !cfg.rd_en;
    if (wr) begin
      if (cfg.wr_addr == SMBC_OFS_GATE) begin
        d.gate = cfg.wr_data & SMBC_GATE_MASK;
      end else if (cfg.wr_addr == SMBC_OFS_CTL) begin
        d.ctl = cfg.wr_data & SMBC_CTL_MASK;
      end else if (cfg.wr_addr == SMBC_OFS_EDGE) begin
        d.edge_sel = cfg.wr_data & SMBC_EDGE_MASK;
      end else if (cfg.wr_addr == SMBC_OFS_COUNT) begin
        d.count = cfg.wr_data & SMBC_COUNT_MASK;
      end
    end
  end

  always_comb begin
    if (cfg.rd_addr == SMBC_OFS_GATE) begin
      cfg.rd_data = q.gate;
    end else if (cfg.rd_addr == SMBC_OFS_CTL) begin
      cfg.rd_data = q.ctl | SMBC_CTL_RSV_ONES | ({6'h00, cfg.strap} << SMBC_RB_LSB);
    end else if (cfg.rd_addr == SMBC_OFS_EDGE) begin
      cfg.rd_data = q.edge_sel;
    end else if (cfg.rd_addr == SMBC_OFS_COUNT) begin
      cfg.rd_data = q.count;
    end else begin
      cfg.rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q.gate <= SMBC_GATE_RST;
      q.ctl <= SMBC_CTL_RST;
      q.edge_sel <= SMBC_EDGE_RST;
      q.count <= SMBC_COUNT_RST;
    end else begin
      q <= d;
    end
  end

  assign cfg.wr_ready = !cfg.rd_en;
  assign cfg.gate_byte = q.gate;
  assign cfg.ctl_byte = q.ctl;
  assign cfg.edge_byte = q.edge_sel;
endmodule // smbc_cfg_regs

// [sim/smbc_host_model.sv]
`timescale 1ns/1ns
module smbc_host_model (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  localparam int HALF = 10;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Releases SCL and waits while the device stretches it
  task automatic scl_up();
    int k;
    k = 0;
    scl_low_o = 1'b0;
    while (!scl_i && k < 200) begin
      pause(1);
      k++;
    end
    pause(HALF);
  endtask
  task automatic put_bit(input logic b);
    sda_low_o = !b;
    pause(HALF);
    scl_up();
    scl_low_o = 1'b1;
  endtask
  task automatic get_bit(output logic b);
    sda_low_o = 1'b0;
    pause(HALF);
    scl_up();
    b = sda_i;
    scl_low_o = 1'b1;
  endtask
  // Start, or repeated start when SCL is low
  task automatic start();
    sda_low_o = 1'b0;
    pause(HALF);
    scl_up();
    sda_low_o = 1'b1;
    pause(HALF);
    scl_low_o = 1'b1;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    pause(HALF);
    scl_up();
    sda_low_o = 1'b0;
    pause(HALF);
  endtask
  // Sends a byte MSB first and returns the acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!ack);
  endtask
endmodule // smbc_host_model

// [sim/smbc_checker.sv]
`timescale 1ns/1ns
module smbc_checker
  import smbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic addr_strap_i,
  input wire logic [1:0] spread_strap_i,
  input wire logic [5:0] out_gate_n_i,
  input wire logic [5:0] diff_out_en_o,
  input wire logic [1:0] spread_mode_o,
  input wire logic [1:0] amplitude_o,
  input wire logic [5:0] edge_fast_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence start_cond;
    scl_i && $past(scl_i) && !sda_i && $past(sda_i);
  endsequence
  sequence stop_cond;
    scl_i && $past(scl_i) && sda_i && !$past(sda_i);
  endsequence
  od_zero_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("Open drain data not low");
  ack_hold_a: assert property ($rose(scl_i) && sda_oe_o |-> sda_oe_o [*3])
    else $error("SDA released while SCL high");
  sda_stable_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("SDA changed while SCL high");
  stretch_bound_a: assert property ($rose(scl_oe_o) |-> ##[1:40] !scl_oe_o)
    else $error("Clock stretch too long");
  start_quiet_a: assert property (start_cond |=> !sda_oe_o [*8])
    else $error("SDA driven after start");
  stop_idle_a: assert property (stop_cond |=> (!sda_oe_o && !scl_oe_o) [*8])
    else $error("Bus driven after stop");
  reset_cfg_a: assert property ($fell(reset_i) |-> ##3 (amplitude_o == 2'h2 && edge_fast_o == 6'h3F
    && spread_mode_o == $past(spread_strap_i, 3)))
    else $error("Outputs wrong after reset");
  gate_pin_a: assert property ((diff_out_en_o & $past(out_gate_n_i)) == 6'h00)
    else $error("Output on while gate pin high");
endmodule // smbc_checker
bind smbc_top smbc_checker u_smbc_checker (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_i(addr_strap_i),
  .spread_strap_i(spread_strap_i), .out_gate_n_i(out_gate_n_i), .diff_out_en_o(diff_out_en_o),
  .spread_mode_o(spread_mode_o), .amplitude_o(amplitude_o), .edge_fast_o(edge_fast_o));

// [sim/tb_smbc_top.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_smbc_top;
  import smbc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic addr_strap = 1'b1;
  logic [1:0] spread_strap = SMBC_STRAP_HIGH;
  logic [5:0] gate_n = 6'h00;
  logic scl_oe, sda_oe, h_scl, h_sda, scl, sda, lat_addr, scl_dv, sda_dv;
  logic [5:0] en, edge_fast;
  logic [1:0] mode, amp, lat_strap;
  logic [7:0] regs [8];
  logic [7:0] wq [$];
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  // Pull-ups: a released line reads high
  assign scl = !h_scl && (scl_oe ? scl_dv : 1'b1);
  assign sda = !h_sda && (sda_oe ? sda_dv : 1'b1);
  smbc_top u_smbc_top (.sys_clk_i(clk), .reset_i(rst), .scl_i(scl), .scl_o(scl_dv), .scl_oe_o(scl_oe), .sda_i(sda),
    .sda_o(sda_dv), .sda_oe_o(sda_oe), .addr_strap_i(addr_strap), .spread_strap_i(spread_strap),
    .out_gate_n_i(gate_n), .diff_out_en_o(en), .spread_mode_o(mode), .amplitude_o(amp), .edge_fast_o(edge_fast));
  smbc_host_model u_smbc_host_model (.clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_low_o(h_scl), .sda_low_o(h_sda));
  always begin
    #2 clk = ~clk;
  end
  function automatic logic [7:0] wmask(input int i);
    case (i)
      0, 2: return SMBC_GATE_MASK;
      1: return SMBC_CTL_MASK;
      7: return SMBC_COUNT_MASK;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [5:0] map6(input logic [7:0] b);
    return {b[7], b[6], b[4], b[3], b[2], b[0]};
  endfunction
  function automatic logic [7:0] rd_exp(input int i);
    return (i == 1) ? (regs[1] | SMBC_CTL_RSV_ONES | {lat_strap, 6'h00}) : regs[i];
  endfunction
  function automatic logic [6:0] dev_addr();
    return lat_addr ? SMBC_ADDR_SEL1 : SMBC_ADDR_SEL0;
  endfunction
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Straps move after capture, so only the latched values may matter
  task automatic reset_dut(input logic a, input logic [1:0] s);
    rst = 1'b1;
    addr_strap = a;
    spread_strap = s;
    lat_addr = a;
    lat_strap = s;
    regs = '{SMBC_GATE_RST, SMBC_CTL_RST, SMBC_EDGE_RST, 8'h00, 8'h00, 8'h00, 8'h00, SMBC_COUNT_RST};
    u_smbc_host_model.pause(5);
    rst = 1'b0;
    u_smbc_host_model.pause(3);
    addr_strap = !a;
    spread_strap = ~s;
    u_smbc_host_model.pause(20);
  endtask
  task automatic wr_block(input logic [7:0] idx, input logic [7:0] cnt);
    logic a;
    u_smbc_host_model.start();
    u_smbc_host_model.put_byte({dev_addr(), 1'b0}, a);
    `CHK(a, 1'b1)
    u_smbc_host_model.put_byte(idx, a);
    `CHK(a, 1'b1)
    u_smbc_host_model.put_byte(cnt, a);
    `CHK(a, 1'b1)
    foreach (wq[i]) begin
      u_smbc_host_model.put_byte(wq[i], a);
      `CHK(a, i < cnt)
      if (i < cnt && idx + i < 8)
        regs[idx + i] = (regs[idx + i] & ~wmask(idx + i)) | (wq[i] & wmask(idx + i));
    end
    u_smbc_host_model.stop();
    wq = {};
  endtask
  task automatic rd_check(input logic [7:0] idx, input int n);
    logic a;
    logic [7:0] d;
    u_smbc_host_model.start();
    u_smbc_host_model.put_byte({dev_addr(), 1'b0}, a);
    u_smbc_host_model.put_byte(idx, a);
    u_smbc_host_model.start();
    u_smbc_host_model.put_byte({dev_addr(), 1'b1}, a);
    `CHK(a, 1'b1)
    u_smbc_host_model.get_byte(1'b1, d);
    `CHK(d, regs[7])
    for (int i = 0; i < n; i++) begin
      u_smbc_host_model.get_byte(i < n - 1, d);
      `CHK(d, rd_exp(idx + i))
    end
    u_smbc_host_model.stop();
  endtask
  task automatic out_check();
    u_smbc_host_model.pause(5);
    `CHK(en, map6(regs[0]) & ~gate_n)
    `CHK(mode, regs[1][5] ? regs[1][4:3] : lat_strap)
    `CHK(amp, regs[1][1:0])
    `CHK(edge_fast, map6(regs[2]))
  endtask
  initial begin
    logic a;
    logic [7:0] r;
    void'($urandom(32'h624C));
    reset_dut(1'b1, SMBC_STRAP_HIGH);
    rd_check(8'h00, 8);
    out_check();
    // The other strap address is refused
    u_smbc_host_model.start();
    u_smbc_host_model.put_byte({dev_addr() ^ 7'h02, 1'b0}, a);
    `CHK(a, 1'b0)
    u_smbc_host_model.stop();
    // Every software spread code, with and without override
    for (int k = 0; k < 8; k++) begin
      gate_n = 6'($urandom);
      r = 8'($urandom);
      wq.push_back(k == 0 ? 8'h00 : 8'($urandom));
      wq.push_back({r[7:6], k[2:0], r[2:0]});
      wq.push_back(k == 1 ? 8'hFF : 8'($urandom));
      wr_block(8'h00, 8'h03);
      out_check();
      rd_check(8'h00, 3);
    end
    // Count byte rewritten; byte past the count is refused
    wq.push_back(8'hE3);
    wq.push_back(8'h55);
    wr_block(8'h07, 8'h01);
    rd_check(8'h01, 3);
    reset_dut(1'b0, SMBC_STRAP_MID);
    rd_check(8'h00, 8);
    out_check();
    // Low strap level reads back as zeros and drives spread off
    reset_dut(1'b1, SMBC_STRAP_LOW);
    rd_check(8'h01, 1);
    out_check();
    conclude();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      conclude();
    end
  end
endmodule // tb_smbc_top
